// ===== rtl/aprp_read_port.sv
// Parallel read port of a 10-bit sampling converter, as seen by the host.
// Assumes host strobes synchronous to ref_clk; sample comes from the core.
// Notes on behaviour
// R1: Read strobe low while chip select low starts a new conversion.
// R2: Data outputs driven only while both strobes low, else released.
// R3: Read strobe is ignored entirely while chip select is high.
// R4: Busy low during a whole conversion, high otherwise.
// R5: Conversion finishes within 2.5 us, typically 1.9 us.
// R6: Host keeps strobe-only read pulses to 300 ns or less.
// R7: The two reserved low data bits are always driven low.
// R8: At conversion end busy rises and result is latched for reading.
// R9: Strobe length selects handshake or strobe-only mode.
// R10: Result is natural binary, zeros at low reference, ones at high.
// R11: In handshake mode host holds strobes until busy rises.
`timescale 1ns/1ps
module aprp_read_port #(
    parameter int CONV_CYC = aprp_pkg::CONV_CYCLES
) (
    input  wire logic                   ref_clk,
    input  wire logic                   rst_n,
    input  wire aprp_pkg::aprp_host_t   host,
    input  wire logic [aprp_pkg::RES_W-1:0] analog_sample,
    output logic                        busy_ff,
    output aprp_pkg::aprp_data_t        data_out_ff,
    output logic                        data_oe_ff,
    output logic                        strobe_mode_ff
);
    import aprp_pkg::*;

    aprp_state_t      state_ff;
    logic [7:0]       cnt_ff;
    logic [7:0]       rd_len_ff;
    logic             sel;
    logic             sel_q_ff;
    logic             start;
    logic [RES_W-1:0] result_ff;

    // Chip select gates the read strobe, as an internal NOR would
    // R3 strobe gated by select
    assign sel   = ~host.cs_n & ~host.rd_n;
    // R1 start on rising select
    assign start = sel & ~sel_q_ff & (state_ff == AP_IDLE);

    // Edge history of the gated strobe
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sel_q_ff <= 1'b0;
        end else begin
            sel_q_ff <= sel;
        end
    end

    // Conversion sequencer; the count is set by CONV_CYC, within the limit at its default of 47
    // R5 conversion timing
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_ff <= AP_IDLE;
            cnt_ff   <= 8'h00;
        end else begin
            case (state_ff)
                AP_IDLE: begin
                    if (start) begin
                        state_ff <= AP_CONV;
                        cnt_ff   <= 8'(CONV_CYC - 1);
                    end
                end
                AP_CONV: begin
                    if (cnt_ff == 8'h00) begin
                        state_ff <= AP_WAIT;
                    end else begin
                        cnt_ff <= cnt_ff - 8'h01;
                    end
                end
                // Wait for strobes to rise so one pulse is one conversion
                AP_WAIT: begin
                    if (!sel) begin
                        state_ff <= AP_IDLE;
                    end
                end
                default: begin
                    state_ff <= AP_IDLE;
                end
            endcase
        end
    end

    // R4 busy low while converting
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            busy_ff <= BUSY_RST;
        end else begin
            busy_ff <= !(start || (state_ff == AP_CONV && cnt_ff != 8'h00));
        end
    end

    // R8 latch result at end
    // R10 natural binary passed unchanged from the core
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            result_ff <= '0;
        end else if (state_ff == AP_CONV && cnt_ff == 8'h00) begin
            result_ff <= analog_sample;
        end
    end

    // R2 drive only under select
    // R7 reserved bits low
    // Data shows the last latched result until the new one lands
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            data_oe_ff  <= 1'b0;
            data_out_ff <= '0;
        end else begin
            data_oe_ff                    <= sel;
            data_out_ff.reserved_low_bits <= '0;
            if (state_ff == AP_CONV && cnt_ff == 8'h00) begin
                data_out_ff.result_bus <= analog_sample;
            end else begin
                data_out_ff.result_bus <= result_ff;
            end
        end
    end

    // R9 strobe length picks mode
    // A short pulse means strobe-only use: the host reads the old result
    // R6 short pulse threshold
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rd_len_ff      <= 8'h00;
            strobe_mode_ff <= 1'b0;
        end else if (sel) begin
            if (rd_len_ff != 8'hFF) begin
                rd_len_ff <= rd_len_ff + 8'h01;
            end
        end else begin
            if (sel_q_ff) begin
                strobe_mode_ff <= (rd_len_ff <= 8'(STROBE_CYCLES));
            end
            rd_len_ff <= 8'h00;
        end
    end

    // Helper for the R5 bound: cycles that busy has stood low
    // A counter keeps the check cheap where a long repetition would not
    logic [7:0] busy_low_cnt_ff;
    always_ff @(posedge ref_clk) begin
        if (!rst_n || busy_ff) begin
            busy_low_cnt_ff <= 8'h00;
        end else if (busy_low_cnt_ff != 8'hFF) begin
            busy_low_cnt_ff <= busy_low_cnt_ff + 8'h01;
        end
    end

    // Steps of one conversion: the start, then busy held low
    sequence s_conv_start;
        start;
    endsequence
    sequence s_busy_low;
        !busy_ff [*8];
    endsequence

    // R4 busy falls one cycle after start
    a_busy_start_low: assert property ( // R4
        @(posedge ref_clk) disable iff (!rst_n)
        s_conv_start |=> !busy_ff)
        else $error("busy did not fall on start");

    // R5 conversion length bounded
    a_conv_end_bound: assert property ( // R5
        @(posedge ref_clk) disable iff (!rst_n)
        s_conv_start |-> ##[1:62] busy_ff)
        else $error("conversion exceeded limit");

    // R5 busy never stays low past the longest conversion
    a_busy_low_max: assert property ( // R5
        @(posedge ref_clk) disable iff (!rst_n)
        !busy_ff |-> (busy_low_cnt_ff < 8'(CONV_MAX_CYC)))
        else $error("busy low beyond limit");

    // R4 busy stays low for 8 cycles after start
    a_busy_held_low: assert property ( // R4
        @(posedge ref_clk) disable iff (!rst_n)
        s_conv_start |=> s_busy_low)
        else $error("busy rose too early");

    // R3 chip select high leaves an idle port idle and undriven
    a_cs_blocks_rd: assert property ( // R3
        @(posedge ref_clk) disable iff (!rst_n)
        (host.cs_n && busy_ff) |=> (busy_ff && !data_oe_ff))
        else $error("start without chip select");

    // R2 outputs released
    a_oe_follows_sel: assert property ( // R2
        @(posedge ref_clk) disable iff (!rst_n)
        (host.cs_n || host.rd_n) |=> !data_oe_ff)
        else $error("outputs driven without select");

    // R2 outputs driven while both strobes are low
    a_oe_on_sel: assert property ( // R2
        @(posedge ref_clk) disable iff (!rst_n)
        (!host.cs_n && !host.rd_n) |=> data_oe_ff)
        else $error("outputs not driven under select");

    // R7 reserved bits low
    a_rsv_low: assert property ( // R7
        @(posedge ref_clk) disable iff (!rst_n)
        data_out_ff.reserved_low_bits == '0)
        else $error("reserved bits not low");

    // R8 result on the bus when busy rises is the core sample from the cycle before
    a_result_latch: assert property ( // R8
        @(posedge ref_clk) disable iff (!rst_n)
        $rose(busy_ff) |-> (data_out_ff.result_bus == $past(analog_sample)))
        else $error("result not latched at end");

    // R1 held select gives no second start on the next cycle
    a_one_start: assert property ( // R1
        @(posedge ref_clk) disable iff (!rst_n)
        start |=> !start)
        else $error("repeated start");

    // R9 long pulse gives handshake mode
    a_mode_long: assert property ( // R9
        @(posedge ref_clk) disable iff (!rst_n)
        (!sel && sel_q_ff && rd_len_ff > 8'(STROBE_CYCLES)) |=> !strobe_mode_ff)
        else $error("long pulse not handshake");

    // R9 short pulse gives strobe-only mode
    a_mode_short: assert property ( // R9
        @(posedge ref_clk) disable iff (!rst_n)
        (!sel && sel_q_ff && rd_len_ff <= 8'(STROBE_CYCLES)) |=> strobe_mode_ff)
        else $error("short pulse not strobe-only");

endmodule : aprp_read_port

// ===== shared/aprp_pkg.sv
// Package for the converter parallel read port: timing, widths, carriers.
// Assumes a single 25 MHz clock; no software registers exist.
package aprp_pkg;

    // Clock period in picoseconds
    localparam int CLK_PERIOD_PS  = 40000;
    // Conversion time, longest, in ns
    localparam int CONV_MAX_NS    = 2500;
    // Conversion time, typical, in ns
    localparam int CONV_TYP_NS    = 1900;
    // Read strobe limit in strobe-only mode, in ns
    localparam int STROBE_MAX_NS  = 300;
    // Typical conversion in cycles; a longest time rounds down
    localparam int CONV_CYCLES    = (CONV_TYP_NS * 1000) / CLK_PERIOD_PS;
    localparam int CONV_MAX_CYC   = (CONV_MAX_NS * 1000) / CLK_PERIOD_PS;
    // Strobe length that still counts as strobe-only, rounded down
    localparam int STROBE_CYCLES  = (STROBE_MAX_NS * 1000) / CLK_PERIOD_PS;
    localparam int RES_W          = 10;
    localparam int RSV_W          = 2;
    // Busy output value after reset: idle, high
    localparam logic BUSY_RST     = 1'b1;

    // Host strobes, both active low
    typedef struct packed {
        logic cs_n;
        logic rd_n;
    } aprp_host_t;

    // Driven data bus: reserved bits below the result
    typedef struct packed {
        logic [RES_W-1:0] result_bus;
        logic [RSV_W-1:0] reserved_low_bits;
    } aprp_data_t;

    typedef enum logic [1:0] {
        AP_IDLE,
        AP_CONV,
        AP_WAIT
    } aprp_state_t;

endpackage : aprp_pkg

// ===== dv/aprp_host_model.sv
// Host model: bus master that strobes the converter read port.
// Assumes the bench calls its tasks; strobes change at falling edges.
`timescale 1ns/1ps
module aprp_host_model (
    input  wire logic            ref_clk,
    input  wire logic            busy_ff,
    output aprp_pkg::aprp_host_t host
);
    import aprp_pkg::*;
    // Both strobes idle high from time zero
    initial host = '{cs_n: 1'b1, rd_n: 1'b1};
    // strobes held
    // Change strobes off the sampling edge; the bench sets pulse length
    task automatic drive(input logic cs_n, input logic rd_n);
        @(negedge ref_clk);
        host = '{cs_n: cs_n, rd_n: rd_n};
    endtask : drive
    // wait for busy
    // Bounded so a stuck busy cannot hang the run
    task automatic wait_busy(input logic lvl, output int cyc);
        cyc = 0;
        while (busy_ff !== lvl && cyc < 200) begin
            @(negedge ref_clk);
            cyc++;
        end
    endtask : wait_busy
endmodule : aprp_host_model

// ===== dv/aprp_read_port_tb.sv
// Testbench for the converter read port: hand-written scenario tasks.
// Assumes the host model drives the strobes; sample driven at negedge.
`timescale 1ns/1ps
module aprp_read_port_tb;
    import aprp_pkg::*;
    logic             ref_clk = 1'b0;
    logic             rst_n   = 1'b0;
    logic [RES_W-1:0] sample  = '0;
    aprp_host_t       host;
    logic             busy;
    aprp_data_t       dout;
    logic             oe;
    logic             mode;
    int               errors = 0;
    int               check_count = 0;

    // 25 MHz clock
    initial forever #20 ref_clk = ~ref_clk;

    aprp_read_port uut (.ref_clk(ref_clk), .rst_n(rst_n), .host(host),
        .analog_sample(sample), .busy_ff(busy), .data_out_ff(dout),
        .data_oe_ff(oe), .strobe_mode_ff(mode));
    aprp_host_model host_m (.ref_clk(ref_clk), .busy_ff(busy),
        .host(host));

    task automatic check(input string nm, input logic [11:0] seen,
                         input logic [11:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic give_verdict();
        if (errors == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict

    // A wait that runs out ends the run as a failure
    task automatic wait_b(input logic lvl, output int c);
        host_m.wait_busy(lvl, c);
        if (c >= 200) begin
            errors++;
            give_verdict();
        end
    endtask : wait_b

    // Strobe with chip select high must do nothing
    task automatic sc_ignored();
        host_m.drive(1'b1, 1'b0);
        repeat (3) @(negedge ref_clk);
        check("busy_ign", 12'(busy), 12'h001);
        check("oe_ign", 12'(oe), 12'h000);
        host_m.drive(1'b1, 1'b1);
    endtask : sc_ignored

    // Handshake read: hold select through conversion, then release
    task automatic sc_handshake(input logic [9:0] s);
        int c;
        sample = s;
        host_m.drive(1'b0, 1'b0);
        wait_b(1'b0, c);
        check("start_lat", 12'(c <= 1), 12'h001);
        check("oe_on", 12'(oe), 12'h001);
        wait_b(1'b1, c);
        check("conv_len", 12'(c), 12'(CONV_CYCLES));
        check("conv_max", 12'(c <= CONV_MAX_CYC), 12'h001);
        check("data", dout, {s, 2'h0});
        repeat (2) @(negedge ref_clk);
        check("no_restart", 12'(busy), 12'h001);
        host_m.drive(1'b1, 1'b1);
        repeat (2) @(negedge ref_clk);
        check("oe_off", 12'(oe), 12'h000);
        check("mode_hs", 12'(mode), 12'h000);
    endtask : sc_handshake

    // Strobe-only read: short pulse shows the old result, new one follows
    task automatic sc_strobe(input logic [9:0] s, input logic [9:0] prev);
        int c;
        sample = s;
        host_m.drive(1'b0, 1'b0);
        repeat (3) @(negedge ref_clk);
        check("oe_so_on", 12'(oe), 12'h001);
        check("busy_so", 12'(busy), 12'h000);
        check("old_so", dout, {prev, 2'h0});
        host_m.drive(1'b1, 1'b1);
        wait_b(1'b1, c);
        check("mode_so", 12'(mode), 12'h001);
        check("oe_so", 12'(oe), 12'h000);
        check("data_so", dout, {s, 2'h0});
    endtask : sc_strobe

    // Reset in mid-conversion returns every output to its idle value
    task automatic sc_reset();
        host_m.drive(1'b0, 1'b0);
        repeat (3) @(negedge ref_clk);
        check("busy_pre", 12'(busy), 12'h000);
        rst_n = 1'b0;
        host_m.drive(1'b1, 1'b1);
        repeat (2) @(negedge ref_clk);
        check("busy_mrst", 12'(busy), 12'(BUSY_RST));
        check("oe_mrst", 12'(oe), 12'h000);
        check("mode_mrst", 12'(mode), 12'h000);
        check("data_mrst", dout, 12'h000);
        rst_n = 1'b1;
    endtask : sc_reset

    initial begin
        repeat (6) @(negedge ref_clk);
        check("busy_rst", 12'(busy), 12'(BUSY_RST));
        check("oe_rst", 12'(oe), 12'h000);
        rst_n = 1'b1;
        sc_ignored();
        sc_strobe(10'h155, 10'h000);
        sc_handshake(10'h3FF);
        sc_strobe(10'h0AA, 10'h3FF);
        sc_reset();
        sc_handshake(10'h2A5);
        sc_handshake(10'h000);
        give_verdict();
    end
endmodule : aprp_read_port_tb
